// ==== logic/sac_consts.vh ====
// Register offsets, field positions, reset values and timing counts of the converter control
`ifndef SAC_CONSTS_VH
`define SAC_CONSTS_VH
// Register indices; the byte address on the bus is four times the index
`define SAC_IDX_PIN_EN_LOW      8'h92
`define SAC_IDX_PIN_EN_HIGH     8'h93
`define SAC_IDX_MODE            8'h9A
`define SAC_IDX_RESULT_HIGH     8'h9B
`define SAC_IDX_MODE_SECOND     8'h9B
`define SAC_IDX_RESULT_LOW      8'h9C
`define SAC_IDX_IRQ_STATUS      8'hA0
`define SAC_IDX_IRQ_ENABLE      8'hA1
`define SAC_IDX_IRQ_CLEAR       8'hA2
`define SAC_IDX_TRIG_ENABLE     8'hA3
// Mode register fields
`define SAC_MODE_POWER_DOWN     7
`define SAC_MODE_START          6
`define SAC_MODE_REF_SEL        5
`define SAC_MODE_DONE           4
// Second mode register fields
`define SAC_MODE2_ALIGN         2
// Reset values
`define SAC_RST_MODE            8'h8F
`define SAC_RST_MODE_SECOND     8'h01
`define SAC_RST_PIN_EN          8'h00
// Timing
`define SAC_CONV_CYCLES         7'h3C
`define SAC_DIV2                8'h01
`define SAC_DIV4                8'h03
`define SAC_DIV8                8'h07
`define SAC_DIV32               8'h1F
`endif

// ==== logic/sac_control.v ====
// Control unit for a 12-bit successive-approximation converter with APB registers
// Operation
// - Channel codes route pins, internal sources, unconnected
// - Start bit one starts, zero stops
// - Completion loads result, sets flag, raises interrupt
// - Done flag reads zero during conversion
// - Conversion lasts exactly sixty converter clocks
// - Power-down bit disables the converter
// - Shared address reads result or mode two
// - Reference select one disables channel zero
// - Align bit places result in registers
// - Clock select divides by 2,4,8,32
// - Pin enable bits gate analog channels
// - Hardware triggers also start conversions
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "sac_consts.vh"
module sac_control #(
    parameter RES_W = 12
) (
    // Clock and reset
    input  wire               clk,
    input  wire               reset_n,
    // APB slave
    input  wire               psel,
    input  wire               penable,
    input  wire               pwrite,
    input  wire [11:0]        paddr,
    input  wire [31:0]        pwdata,
    output reg  [31:0]        prdata,
    output reg                pready,
    output reg                pslverr,
    // Hardware start triggers (asynchronous sources)
    input  wire [3:0]         hwTrigger,
    // Analog core
    input  wire [RES_W-1:0]   coreResult,
    output reg                coreEnable,
    output reg                coreSample,
    output reg                converterClock,
    output reg  [3:0]         coreChannel,
    output reg                coreChannelValid,
    output reg                coreInternalSource,
    output reg                coreExtReference,
    output reg  [9:0]         analogPinEnable,
    // Interrupt
    output reg                irq
);
    // ==========================================================
    // Registers
    reg  [7:0]       modeReg;
    reg  [7:0]       mode2Reg;
    reg  [7:0]       pinLowReg;
    reg  [1:0]       pinHighReg;
    reg  [RES_W-1:0] resultReg;
    reg              doneReg;
    reg  [6:0]       cycleCountReg;
    reg  [7:0]       divCountReg;
    reg  [3:0]       trigSync1Reg;
    reg  [3:0]       trigSync2Reg;
    reg  [3:0]       trigPrevReg;
    reg  [3:0]       trigEnableReg;
    reg              irqStatusReg;
    reg              irqEnableReg;
    reg  [7:0]       resHigh;
    reg  [7:0]       resLow;
    reg  [7:0]       divLimit;
    reg  [7:0]       readByte;
    wire [9:0]       wordIdx = paddr[11:2];
    wire             wrStrobe = psel & penable & pwrite;
    wire             rdAccess = psel & ~penable & ~pwrite;
    wire             powerDown = modeReg[`SAC_MODE_POWER_DOWN];
    wire             swStart = wrStrobe && (wordIdx == {2'b00, `SAC_IDX_MODE})
                               && pwdata[`SAC_MODE_START];
    wire             swStop = wrStrobe && (wordIdx == {2'b00, `SAC_IDX_MODE})
                              && !pwdata[`SAC_MODE_START];
    wire [3:0]       trigRise = trigSync2Reg & ~trigPrevReg & trigEnableReg;
    wire             tick = (divCountReg == divLimit);
    wire             busy = modeReg[`SAC_MODE_START];
    wire             finish = busy && tick && (cycleCountReg == `SAC_CONV_CYCLES - 7'h01);
    wire             anyStart = (swStart || (|trigRise)) && !powerDown;
    wire             modeWrite = wrStrobe && (wordIdx == {2'b00, `SAC_IDX_MODE});
    wire             pdWrite = modeWrite && pwdata[`SAC_MODE_POWER_DOWN];
    // Power-down outranks every start, stop and completion in the same cycle
    wire             haltNow = powerDown || pdWrite;
    // A completion only counts when nothing else claims that cycle
    wire             loadNow = finish && !haltNow && !anyStart && !swStop;
    wire             irqClear = wrStrobe && (wordIdx == {2'b00, `SAC_IDX_IRQ_CLEAR})
                                && pwdata[0];

    // ==========================================================
    // Clock divider select
    // Divider by code
    always @* begin
        case (mode2Reg[1:0])
            2'b00: divLimit = `SAC_DIV2;
            2'b01: divLimit = `SAC_DIV4;
            2'b10: divLimit = `SAC_DIV8;
            default: divLimit = `SAC_DIV32;
        endcase
    end

    // ==========================================================
    // Result alignment
    // Align placement
    always @* begin
        if (mode2Reg[`SAC_MODE2_ALIGN]) begin
            resHigh = {4'h0, resultReg[11:8]};
            resLow  = resultReg[7:0];
        end else begin
            resHigh = resultReg[11:4];
            resLow  = {resultReg[3:0], 4'h0};
        end
    end

    // ==========================================================
    // Trigger synchronisers
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            trigSync1Reg <= 4'h0;
            trigSync2Reg <= 4'h0;
            trigPrevReg  <= 4'h0;
        end else begin
            trigSync1Reg <= hwTrigger;
            trigSync2Reg <= trigSync1Reg;
            trigPrevReg  <= trigSync2Reg;
        end
    end

    // ==========================================================
    // Mode register
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            modeReg <= `SAC_RST_MODE;
        end else begin
            if (modeWrite) begin
                // Done position is read-only and stays zero here
                modeReg[7:5] <= pwdata[7:5];
                modeReg[3:0] <= pwdata[3:0];
            end
            if (|trigRise && !powerDown) begin
                modeReg[`SAC_MODE_START] <= 1'b1;
            end
            if (haltNow) begin
                modeReg[`SAC_MODE_START] <= 1'b0;
            end else if (loadNow) begin
                modeReg[`SAC_MODE_START] <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Second mode register
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mode2Reg <= `SAC_RST_MODE_SECOND;
        end else if (wrStrobe && (wordIdx == {2'b00, `SAC_IDX_MODE_SECOND})) begin
            mode2Reg <= pwdata[7:0];
        end
    end

    // ==========================================================
    // Pin enable registers
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pinLowReg <= `SAC_RST_PIN_EN;
        end else if (wrStrobe && (wordIdx == {2'b00, `SAC_IDX_PIN_EN_LOW})) begin
            pinLowReg <= pwdata[7:0];
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pinHighReg <= 2'b00;
        end else if (wrStrobe && (wordIdx == {2'b00, `SAC_IDX_PIN_EN_HIGH})) begin
            // Only channels nine and eight exist up here
            pinHighReg <= pwdata[1:0];
        end
    end

    // ==========================================================
    // Interrupt and trigger enables
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irqEnableReg <= 1'b0;
        end else if (wrStrobe && (wordIdx == {2'b00, `SAC_IDX_IRQ_ENABLE})) begin
            irqEnableReg <= pwdata[0];
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            trigEnableReg <= 4'h0;
        end else if (wrStrobe && (wordIdx == {2'b00, `SAC_IDX_TRIG_ENABLE})) begin
            trigEnableReg <= pwdata[3:0];
        end
    end

    // ==========================================================
    // Converter clock divider
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            divCountReg <= 8'h00;
        end else if (anyStart && !haltNow) begin
            divCountReg <= 8'h00;
        end else if (tick) begin
            divCountReg <= 8'h00;
        end else begin
            divCountReg <= divCountReg + 8'h01;
        end
    end

    // ==========================================================
    // Conversion cycle counter
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cycleCountReg <= 7'h00;
        end else if (haltNow || anyStart || swStop || loadNow) begin
            cycleCountReg <= 7'h00;
        end else if (busy && tick) begin
            cycleCountReg <= cycleCountReg + 7'h01;
        end
    end

    // ==========================================================
    // Completion flag and result
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            doneReg <= 1'b0;
        end else if (anyStart && !haltNow) begin
            doneReg <= 1'b0;
        end else if (loadNow) begin
            doneReg <= 1'b1;
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            resultReg <= {RES_W{1'b0}};
        end else if (loadNow) begin
            resultReg <= coreResult;
        end
    end

    // ==========================================================
    // Interrupt status
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irqStatusReg <= 1'b0;
        end else if (loadNow) begin
            irqStatusReg <= 1'b1;
        end else if (irqClear) begin
            irqStatusReg <= 1'b0;
        end
    end

    // ==========================================================
    // Read multiplexer
    always @* begin
        readByte = 8'h00;
        case (wordIdx)
            {2'b00, `SAC_IDX_MODE}:
                readByte = {modeReg[7:5], doneReg & ~busy, modeReg[3:0]};
            {2'b00, `SAC_IDX_RESULT_HIGH}: readByte = powerDown ? mode2Reg : resHigh;
            {2'b00, `SAC_IDX_RESULT_LOW}:  readByte = resLow;
            {2'b00, `SAC_IDX_PIN_EN_LOW}:  readByte = pinLowReg;
            {2'b00, `SAC_IDX_PIN_EN_HIGH}: readByte = {6'h00, pinHighReg};
            {2'b00, `SAC_IDX_IRQ_STATUS}:  readByte = {7'h00, irqStatusReg};
            {2'b00, `SAC_IDX_IRQ_ENABLE}:  readByte = {7'h00, irqEnableReg};
            {2'b00, `SAC_IDX_TRIG_ENABLE}: readByte = {4'h0, trigEnableReg};
            default:                       readByte = 8'h00;
        endcase
    end

    // ==========================================================
    // APB read path, zero wait states
    // Data is launched at the setup edge so it stands through the access cycle
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            if (rdAccess) begin
                prdata <= {24'h00_0000, readByte};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // ==========================================================
    // Analog core drive
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            coreEnable         <= 1'b0;
            coreSample         <= 1'b0;
            converterClock     <= 1'b0;
            coreChannel        <= 4'h0;
            coreChannelValid   <= 1'b0;
            coreInternalSource <= 1'b0;
            coreExtReference   <= 1'b0;
            analogPinEnable    <= 10'h000;
            irq                <= 1'b0;
        end else begin
            coreEnable     <= ~powerDown;
            coreSample     <= busy && !powerDown;
            converterClock <= (divCountReg > (divLimit >> 1));
            coreChannel    <= modeReg[3:0];
            coreChannelValid <= (modeReg[3:0] != 4'hB) && (modeReg[3:0] != 4'hF)
                                && !(modeReg[3:0] == 4'h0 && modeReg[`SAC_MODE_REF_SEL]);
            coreInternalSource <= modeReg[3:0] >= 4'hA;
            coreExtReference <= modeReg[`SAC_MODE_REF_SEL];
            // Pin enables, channel zero lost to reference
            analogPinEnable <= {pinHighReg, pinLowReg[7:1],
                                pinLowReg[0] & ~modeReg[`SAC_MODE_REF_SEL]};
            irq <= irqStatusReg & irqEnableReg;
        end
    end
endmodule
`default_nettype wire

// ==== test/sac_core_model.sv ====
// Behavioural model of the analog converter core
`timescale 1ns/1ps
`default_nettype none
module sac_core_model (
    // From the unit
    input  wire logic        clk,
    input  wire logic        coreEnable,
    input  wire logic        coreSample,
    input  wire logic [3:0]  coreChannel,
    // To the unit
    output wire logic [11:0] coreResult
);
    logic [11:0] resultQ = 12'h000;
    logic [3:0]  warmCount = 4'h0;
    assign coreResult = resultQ;
    always @(posedge clk) begin
        if (!coreEnable) begin
            warmCount <= 4'h0;
        end else if (warmCount != 4'hF) begin
            warmCount <= warmCount + 4'h1;
        end
    end
    // Good value only while running and settled
    // Toggles otherwise so that a stale or early result cannot pass unseen
    always @(posedge clk) begin
        if (coreEnable && coreSample && warmCount == 4'hF) begin
            resultQ <= {coreChannel, 8'h5A};
        end else begin
            resultQ <= ~resultQ;
        end
    end
endmodule
`default_nettype wire

// ==== test/sac_control_sva.sv ====
// Concurrent checks on the converter control ports
`timescale 1ns/1ps
`default_nettype none
module sac_control_sva (
    // Clock, reset, bus
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    // Core side
    input wire logic        coreEnable,
    input wire logic        coreSample,
    input wire logic        converterClock,
    input wire logic [3:0]  coreChannel,
    input wire logic        coreChannelValid,
    input wire logic        coreInternalSource,
    input wire logic        coreExtReference,
    input wire logic [9:0]  analogPinEnable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // ==========
    // Mode register write
    logic modeWr;
    assign modeWr = psel && penable && pwrite && paddr == 12'h268;
    bus_ready_a: assert property (psel && !penable |=> pready) else $error("no ready");
    chan_source_a: assert property (coreInternalSource == (coreChannel >= 4'hA))
        else $error("bad source");
    chan_open_a: assert property ((coreChannel == 4'hB || coreChannel == 4'hF)
        |-> !coreChannelValid) else $error("open channel valid");
    ext_ref_a: assert property (coreExtReference |-> !analogPinEnable[0]
        && !(coreChannel == 4'h0 && coreChannelValid)) else $error("pin 0 live");
    idle_down_a: assert property (!coreEnable |=> !coreSample) else $error("run off");
    start_run_a: assert property (modeWr && coreEnable && pwdata[7:6] == 2'b01
        |-> ##[1:4] coreSample) else $error("no start");
    stop_run_a: assert property (modeWr && pwdata[7:6] == 2'b00 |-> ##[1:4] !coreSample)
        else $error("no stop");
    power_off_a: assert property (modeWr && pwdata[7] |-> ##[1:4] !coreEnable)
        else $error("still on");
    clk_run_a: assert property ($rose(coreSample) |-> ##[1:40] $changed(converterClock))
        else $error("clock still");
    cover property ($rose(coreSample));
    cover property ($fell(coreSample) && coreEnable);
    cover property (coreExtReference);
endmodule
bind sac_control sac_control_sva u_sva (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .coreEnable(coreEnable), .coreSample(coreSample), .converterClock(converterClock),
    .coreChannel(coreChannel), .coreChannelValid(coreChannelValid),
    .coreInternalSource(coreInternalSource), .coreExtReference(coreExtReference),
    .analogPinEnable(analogPinEnable));
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking testbench for the converter control unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct packed {logic [11:0] a; logic w; logic [7:0] d;} sac_row_t;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0]  hwTrigger = 4'h0;
    logic [31:0] rd;
    logic        slvErr;
    wire         pslverr;
    wire  [31:0] prdata;
    wire  [11:0] coreResult;
    wire  [3:0]  coreChannel;
    wire  [9:0]  analogPinEnable;
    wire         pready, coreEnable, coreSample, coreChannelValid, coreInternalSource, irq;
    int          err_total = 0;
    int          compares = 0;
    int          n;
    // Rows in order; a read row holds the value it should return
    sac_row_t rows [10] = '{'{12'h268, 1'b0, 8'h8F}, '{12'h26C, 1'b0, 8'h01},
        '{12'h248, 1'b1, 8'hA5}, '{12'h248, 1'b0, 8'hA5}, '{12'h24C, 1'b1, 8'hFF},
        '{12'h24C, 1'b0, 8'h03}, '{12'h3FC, 1'b1, 8'h55}, '{12'h3FC, 1'b0, 8'h00},
        '{12'h26C, 1'b1, 8'h04}, '{12'h26C, 1'b0, 8'h04}};
    always #50 clk = ~clk;
    sac_control DUT (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hwTrigger(hwTrigger), .coreResult(coreResult),
        .coreEnable(coreEnable),
        .coreSample(coreSample), .converterClock(), .coreChannel(coreChannel),
        .coreChannelValid(coreChannelValid), .coreInternalSource(coreInternalSource),
        .coreExtReference(), .analogPinEnable(analogPinEnable), .irq(irq));
    sac_core_model core (.clk(clk), .coreEnable(coreEnable), .coreSample(coreSample),
        .coreChannel(coreChannel), .coreResult(coreResult));
    // ==========
    // Checking and bus tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        slvErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
        apb(a, 1'b0, 8'h00);
        chk(rd, {24'h00_0000, e});
        chk({31'h0, slvErr}, 32'h0000_0000);
    endtask
    task automatic report_and_stop;
        if (err_total == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Far beyond the few hundred cycles the sequence needs
    initial begin
        #2_000_000;
        err_total++;
        report_and_stop;
    end
    // ==========
    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].w) begin
                apb(rows[i].a, 1'b1, rows[i].d);
            end else begin
                rdchk(rows[i].a, rows[i].d);
            end
        end
        // Power-up here; the channel sweep lets the core settle first
        for (int c = 0; c < 16; c++) begin
            apb(12'h268, 1'b1, 8'(c));
            repeat (2) @(posedge clk);
            chk({coreInternalSource, coreChannelValid}, {c >= 10, c != 11 && c != 15});
        end
        apb(12'h284, 1'b1, 8'h01);
        apb(12'h268, 1'b1, 8'h4A);
        rdchk(12'h268, 8'h4A);
        n = 0;
        while (irq !== 1'b1 && n < 400) begin
            @(posedge clk);
            n++;
        end
        chk(n > 110 && n < 124, 1);
        rdchk(12'h268, 8'h1A);
        rdchk(12'h26C, 8'h0A);
        rdchk(12'h270, 8'h5A);
        apb(12'h288, 1'b1, 8'h01);
        rdchk(12'h280, 8'h00);
        chk(irq, 0);
        // Masked event, left alignment, restart midway
        apb(12'h284, 1'b1, 8'h00);
        apb(12'h26C, 1'b1, 8'h00);
        apb(12'h268, 1'b1, 8'h43);
        repeat (50) @(posedge clk);
        apb(12'h268, 1'b1, 8'h43);
        repeat (100) @(posedge clk);
        rdchk(12'h280, 8'h00);
        repeat (30) @(posedge clk);
        rdchk(12'h280, 8'h01);
        chk(irq, 0);
        rdchk(12'h26C, 8'h35);
        rdchk(12'h270, 8'hA0);
        // Start from a hardware event only
        apb(12'h288, 1'b1, 8'h01);
        apb(12'h28C, 1'b1, 8'h01);
        apb(12'h268, 1'b1, 8'h03);
        hwTrigger <= 4'h1;
        repeat (140) @(posedge clk);
        rdchk(12'h280, 8'h01);
        apb(12'h268, 1'b1, 8'hA0);
        rdchk(12'h26C, 8'h00);
        chk(analogPinEnable, 10'h3A4);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rdchk(12'h268, 8'h8F);
        report_and_stop;
    end
endmodule
`default_nettype wire
